// ---- rtl/chmon_top.sv ----
// Decided for this implementation: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - A sync-monitored channel that enters ready from safe, or enters record, switches its output and lamp to input.
// - Leaving record restores sync monitoring unless repro or input was picked during record.
// - Repro chord with a channel select routes the reproduce head to that channel and lights repro.
// - After reset every channel monitors the reproduce head with its repro lamp lit.
// - Input chord with a channel select routes live input to that channel and lights input.
// - The bias lamp of a channel is lit only while that channel records.
// - The erase lamp of a channel is lit only while that channel records.
// - Tape running off a reel stops the transport, enters unthread and freezes the timer.
// - Each channel holds exactly one arm state and exactly one monitor source at all times.
// - After reset every channel is safe with its safe lamp lit, and safe never enters record.
// - Sync chord with a channel select selects record-head monitoring and lights sync.
// - A channel forced from record to safe must pass through ready again; others are untouched.
module chmon_top #(
   parameter int DEBOUNCE_LEN = chmon_pkg::DEBOUNCE_CYCLES
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [chmon_pkg::CH_COUNT-1:0] panelSel,
   input wire logic [chmon_pkg::FN_COUNT-1:0] panelFn,
   input wire logic tapeOutSupply,
   input wire logic tapeOutTakeup,
   input wire logic recordStart,
   input wire logic recordRun,
   input wire logic rethread,
   input wire logic [chmon_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [chmon_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [chmon_pkg::CH_COUNT-1:0] lampSafe,
   output logic [chmon_pkg::CH_COUNT-1:0] lampReady,
   output logic [chmon_pkg::CH_COUNT-1:0] lampRecord,
   output logic [chmon_pkg::CH_COUNT-1:0] lampSync,
   output logic [chmon_pkg::CH_COUNT-1:0] lampRepro,
   output logic [chmon_pkg::CH_COUNT-1:0] lampInput,
   output logic [chmon_pkg::CH_COUNT-1:0] lampBias,
   output logic [chmon_pkg::CH_COUNT-1:0] lampErase,
   output logic [chmon_pkg::CH_COUNT-1:0] routeRecHead,
   output logic [chmon_pkg::CH_COUNT-1:0] routeReproHead,
   output logic [chmon_pkg::CH_COUNT-1:0] routeInput,
   output logic transportStop,
   output logic unthreadMode,
   output logic timerFreeze
);
   import chmon_pkg::*;

   localparam int N = CH_COUNT;
   localparam int DBW = N + FN_COUNT + TAPE_COUNT;

   typedef struct packed {
      chmon_arm_t [N-1:0] arm;
      chmon_mon_t [N-1:0] monSel;
      logic [N-1:0] autoIn;
      logic [N-1:0] selPrev;
      logic [FN_COUNT-1:0] fnPrev;
      logic runoff;
      logic panelEn;
      logic [N-1:0] lSafe;
      logic [N-1:0] lReady;
      logic [N-1:0] lRec;
      logic [N-1:0] lSync;
      logic [N-1:0] lRepro;
      logic [N-1:0] lInput;
      logic awReady;
      logic wReady;
      logic awHeld;
      logic wHeld;
      logic [ADDR_W-1:0] awAddr;
      logic [31:0] wData;
      logic [3:0] wStrb;
      logic bValid;
      logic [1:0] bResp;
      logic arReady;
      logic rValid;
      logic [31:0] rData;
      logic [1:0] rResp;
   } chmon_state_t;

   chmon_state_t q;
   chmon_state_t d;

   logic [DBW-1:0] dbClean;
   logic [N-1:0] selNow;
   logic [FN_COUNT-1:0] fnNow;
   logic [TAPE_COUNT-1:0] tapeNow;
   logic [N-1:0] swCh;
   logic [FN_COUNT-1:0] swFn;
   logic [FN_COUNT-1:0] ev;
   logic [31:0] statusWord;
   logic [31:0] lampWord;
   chmon_mon_t effMon;

   // ---------------------------------------------------------------
   // Pin conditioning
   // ---------------------------------------------------------------
   chmon_debounce #(
      .WIDTH(DBW),
      .INTERVAL(DEBOUNCE_LEN)
   ) u_debounce (
      .core_clk(core_clk),
      .rst(rst),
      .ce(ce),
      .raw({tapeOutTakeup, tapeOutSupply, panelFn, panelSel}),
      .clean(dbClean),
      .tick()
   );

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      d = q;
      swCh = '0;
      swFn = '0;
      ev = '0;
      effMon = MON_SYNC;
      statusWord = '0;
      lampWord = '0;
      // Panel can be locked out by software; runoff stays live
      selNow = dbClean[N-1:0] & {N{q.panelEn}};
      fnNow = dbClean[N +: FN_COUNT] & {FN_COUNT{q.panelEn}};
      tapeNow = dbClean[N + FN_COUNT +: TAPE_COUNT];
      d.selPrev = selNow;
      d.fnPrev = fnNow;

      // AXI write: address and data accepted in either order
      if (s_axi_awvalid && q.awReady) begin
         d.awHeld = 1'b1;
         d.awAddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && q.wReady) begin
         d.wHeld = 1'b1;
         d.wData = s_axi_wdata;
         d.wStrb = s_axi_wstrb;
      end
      if (q.bValid && s_axi_bready) begin
         d.bValid = 1'b0;
      end
      if (d.awHeld && d.wHeld && !q.bValid) begin
         d.awHeld = 1'b0;
         d.wHeld = 1'b0;
         d.bValid = 1'b1;
         d.bResp = RESP_OKAY;
         case (d.awAddr)
            REG_CTRL: begin
               if (d.wStrb[0]) begin
                  d.panelEn = d.wData[CTRL_PANEL_EN_BIT];
               end
            end
            REG_CMD: begin
               // Needs both low lanes so channel and function agree
               if (d.wStrb[1:0] == 2'h3) begin
                  swCh = d.wData[CMD_CH_LSB +: N];
                  swFn = d.wData[CMD_FN_LSB +: FN_COUNT];
               end
            end
            REG_STATUS, REG_LAMPS: begin
            end
            default: begin
               d.bResp = RESP_SLVERR;
            end
         endcase
      end

      // Tape runoff; a new runoff beats a rethread in the same cycle
      d.runoff = (|tapeNow) | (q.runoff & ~rethread);

      // Per-channel arm state and monitor selection
      for (int c = 0; c < N; c++) begin
         for (int f = 0; f < FN_COUNT; f++) begin
            ev[f] = (selNow[c] & fnNow[f] & ~(q.selPrev[c] & q.fnPrev[f]))
                    | (swCh[c] & swFn[f]);
         end
         case (q.arm[c])
            ARM_SAFE: begin
               if (ev[FN_READY] && !ev[FN_SAFE]) begin
                  d.arm[c] = ARM_READY;
               end
            end
            ARM_READY: begin
               if (ev[FN_SAFE]) begin
                  d.arm[c] = ARM_SAFE;
               end else if (recordStart && recordRun && !q.runoff) begin
                  d.arm[c] = ARM_REC;
               end
            end
            ARM_REC: begin
               if (ev[FN_SAFE]) begin
                  d.arm[c] = ARM_SAFE;
               end else if (ev[FN_READY] || !recordRun || q.runoff) begin
                  d.arm[c] = ARM_READY;
               end
            end
            default: begin
               d.arm[c] = ARM_SAFE;
            end
         endcase
         // Input beats repro beats sync when pressed together
         if (ev[FN_INPUT]) begin
            d.monSel[c] = MON_INPUT;
            d.autoIn[c] = 1'b0;
         end else if (ev[FN_REPRO]) begin
            d.monSel[c] = MON_REPRO;
            d.autoIn[c] = 1'b0;
         end else if (ev[FN_SYNC]) begin
            d.monSel[c] = MON_SYNC;
            d.autoIn[c] = 1'b0;
         end
         if (q.arm[c] == ARM_SAFE && d.arm[c] != ARM_SAFE
             && d.monSel[c] == MON_SYNC) begin
            d.autoIn[c] = 1'b1;
         end
         if (q.arm[c] == ARM_READY && d.arm[c] == ARM_REC
             && d.monSel[c] == MON_SYNC) begin
            d.autoIn[c] = 1'b1;
         end
         if ((q.arm[c] == ARM_REC && d.arm[c] != ARM_REC)
             || d.arm[c] == ARM_SAFE) begin
            d.autoIn[c] = 1'b0;
         end
         effMon = d.autoIn[c] ? MON_INPUT : d.monSel[c];
         d.lSafe[c] = (d.arm[c] == ARM_SAFE);
         d.lReady[c] = (d.arm[c] == ARM_READY);
         d.lRec[c] = (d.arm[c] == ARM_REC);
         d.lSync[c] = (effMon == MON_SYNC);
         d.lRepro[c] = (effMon == MON_REPRO);
         d.lInput[c] = (effMon == MON_INPUT);
         statusWord[ST_ARM_LSB + 2*c +: 2] = q.arm[c];
         statusWord[ST_MON_LSB + 2*c +: 2] = q.autoIn[c] ? MON_INPUT
                                                          : q.monSel[c];
      end
      statusWord[ST_RUNOFF_BIT] = q.runoff;
      lampWord[LAMP_SAFE_LSB +: N] = q.lSafe;
      lampWord[LAMP_READY_LSB +: N] = q.lReady;
      lampWord[LAMP_REC_LSB +: N] = q.lRec;
      lampWord[LAMP_SYNC_LSB +: N] = q.lSync;
      lampWord[LAMP_REPRO_LSB +: N] = q.lRepro;
      lampWord[LAMP_INPUT_LSB +: N] = q.lInput;
      lampWord[LAMP_BIAS_LSB +: N] = q.lRec;
      lampWord[LAMP_ERASE_LSB +: N] = q.lRec;

      // AXI read: one beat, answered the cycle after the address
      if (q.rValid && s_axi_rready) begin
         d.rValid = 1'b0;
      end
      if (s_axi_arvalid && q.arReady) begin
         d.rValid = 1'b1;
         d.rResp = RESP_OKAY;
         case (s_axi_araddr)
            REG_CTRL: begin
               d.rData = '0;
               d.rData[CTRL_PANEL_EN_BIT] = q.panelEn;
            end
            REG_CMD: begin
               d.rData = '0;
            end
            REG_STATUS: begin
               d.rData = statusWord;
            end
            REG_LAMPS: begin
               d.rData = lampWord;
            end
            default: begin
               d.rData = '0;
               d.rResp = RESP_SLVERR;
            end
         endcase
      end
      // Readies are registered, so stall while an answer is pending
      d.awReady = !d.awHeld && !d.bValid;
      d.wReady = !d.wHeld && !d.bValid;
      d.arReady = !d.rValid;
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (rst) begin
         q <= '0;
         q.panelEn <= PANEL_EN_RESET;
         q.lSafe <= '1;
         q.lRepro <= '1;
         for (int c = 0; c < N; c++) begin
            q.arm[c] <= ARM_RESET;
            q.monSel[c] <= MON_RESET;
         end
      end else if (ce) begin
         q <= d;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign s_axi_awready = q.awReady;
   assign s_axi_wready = q.wReady;
   assign s_axi_bvalid = q.bValid;
   assign s_axi_bresp = q.bResp;
   assign s_axi_arready = q.arReady;
   assign s_axi_rvalid = q.rValid;
   assign s_axi_rdata = q.rData;
   assign s_axi_rresp = q.rResp;
   assign lampSafe = q.lSafe;
   assign lampReady = q.lReady;
   assign lampRecord = q.lRec;
   assign lampSync = q.lSync;
   assign lampRepro = q.lRepro;
   assign lampInput = q.lInput;
   // Bias and erase drive follow record exactly
   assign lampBias = q.lRec;
   assign lampErase = q.lRec;
   assign routeRecHead = q.lSync;
   assign routeReproHead = q.lRepro;
   assign routeInput = q.lInput;
   assign transportStop = q.runoff;
   assign unthreadMode = q.runoff;
   assign timerFreeze = q.runoff;
endmodule
`default_nettype wire

// ---- pkg/chmon_pkg.sv ----
package chmon_pkg;
   // ---------------------------------------------------------------
   // Geometry
   // ---------------------------------------------------------------
   localparam int CH_COUNT = 4;
   localparam int FN_COUNT = 5;
   localparam int FN_SAFE = 0;
   localparam int FN_READY = 1;
   localparam int FN_SYNC = 2;
   localparam int FN_REPRO = 3;
   localparam int FN_INPUT = 4;
   localparam int TAPE_COUNT = 2;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_MHZ = 50;
   localparam int DEBOUNCE_US = 10000;
   localparam int DEBOUNCE_CYCLES = DEBOUNCE_US * CLK_MHZ;

   // ---------------------------------------------------------------
   // Register map (byte addresses)
   // ---------------------------------------------------------------
   localparam int ADDR_W = 4;
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_CMD = 4'h4;
   localparam logic [3:0] REG_STATUS = 4'h8;
   localparam logic [3:0] REG_LAMPS = 4'hC;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   localparam int CTRL_PANEL_EN_BIT = 0;
   localparam logic PANEL_EN_RESET = 1'b1;
   localparam int CMD_CH_LSB = 0;
   localparam int CMD_FN_LSB = 4;
   localparam int ST_ARM_LSB = 0;
   localparam int ST_MON_LSB = 8;
   localparam int ST_RUNOFF_BIT = 16;
   localparam int LAMP_SAFE_LSB = 0;
   localparam int LAMP_READY_LSB = 4;
   localparam int LAMP_REC_LSB = 8;
   localparam int LAMP_SYNC_LSB = 12;
   localparam int LAMP_REPRO_LSB = 16;
   localparam int LAMP_INPUT_LSB = 20;
   localparam int LAMP_BIAS_LSB = 24;
   localparam int LAMP_ERASE_LSB = 28;

   // ---------------------------------------------------------------
   // Channel modes
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {ARM_SAFE, ARM_READY, ARM_REC} chmon_arm_t;
   typedef enum logic [1:0] {MON_SYNC, MON_REPRO, MON_INPUT} chmon_mon_t;

   localparam chmon_arm_t ARM_RESET = ARM_SAFE;
   localparam chmon_mon_t MON_RESET = MON_REPRO;
endpackage

// ---- rtl/chmon_debounce.sv ----
`timescale 1ns/1ns
`default_nettype none
module chmon_debounce #(
   parameter int WIDTH = 11,
   parameter int INTERVAL = chmon_pkg::DEBOUNCE_CYCLES
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [WIDTH-1:0] raw,
   output logic [WIDTH-1:0] clean,
   output logic tick
);
   import chmon_pkg::*;

   localparam int CW = $clog2(INTERVAL + 1);

   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] moved;
      logic [WIDTH-1:0] clean;
      logic [CW-1:0] cnt;
      logic tick;
   } chmon_db_state_t;

   chmon_db_state_t q;
   chmon_db_state_t d;
   logic [WIDTH-1:0] movedNow;

   // A bit is accepted only if stage two and three agreed through the
   // whole interval; one bounce anywhere defers it to the next one.
   always_comb begin
      d = q;
      d.s1 = raw;
      d.s2 = q.s1;
      d.s3 = q.s2;
      d.tick = 1'b0;
      movedNow = q.moved | (q.s2 ^ q.s3);
      if (q.cnt == CW'(INTERVAL - 1)) begin
         d.cnt = '0;
         d.tick = 1'b1;
         d.clean = (q.clean & movedNow) | (q.s3 & ~movedNow);
         d.moved = '0;
      end else begin
         d.cnt = q.cnt + 1'b1;
         d.moved = movedNow;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         q <= '0;
      end else if (ce) begin
         q <= d;
      end
   end

   assign clean = q.clean;
   assign tick = q.tick;
endmodule
`default_nettype wire

// ---- verif/chmon_top_properties.sv ----
`timescale 1ns/1ns
`default_nettype none
module chmon_top_chk (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic recordStart,
   input wire logic recordRun,
   input wire logic transportStop,
   input wire logic [chmon_pkg::CH_COUNT-1:0] lampSafe,
   input wire logic [chmon_pkg::CH_COUNT-1:0] lampReady,
   input wire logic [chmon_pkg::CH_COUNT-1:0] lampRecord,
   input wire logic [chmon_pkg::CH_COUNT-1:0] lampSync,
   input wire logic [chmon_pkg::CH_COUNT-1:0] lampRepro,
   input wire logic [chmon_pkg::CH_COUNT-1:0] lampInput,
   input wire logic [chmon_pkg::CH_COUNT-1:0] lampBias,
   input wire logic [chmon_pkg::CH_COUNT-1:0] lampErase
);
   import chmon_pkg::*;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);
   // ------------------------------------------------------------------
   // Whole panel
   // ------------------------------------------------------------------
   biasRec_a: assert property (lampBias == lampRecord)
      else $error("bias lamp differs from record state");
   eraseRec_a: assert property (lampErase == lampRecord)
      else $error("erase lamp differs from record state");
   runoffDrop_a: assert property (
      transportStop && ce |=> lampRecord == 4'h0)
      else $error("record survived tape runoff");
   // ------------------------------------------------------------------
   // Per channel
   // ------------------------------------------------------------------
   for (genvar c = 0; c < CH_COUNT; c++) begin : g_ch
      armOne_a: assert property (
         $onehot({lampSafe[c], lampReady[c], lampRecord[c]}))
         else $error("arm state not one-hot");
      monOne_a: assert property (
         $onehot({lampSync[c], lampRepro[c], lampInput[c]}))
         else $error("monitor source not one-hot");
      safeNoRec_a: assert property (lampSafe[c] |=> !lampRecord[c])
         else $error("safe channel went to record");
      recStart_a: assert property (
         $rose(lampRecord[c]) |-> $past(lampReady[c]) && $past(recordStart)
            && $past(recordRun) && !$past(transportStop))
         else $error("record entered without ready and start");
      autoIn_a: assert property (
         $fell(lampSafe[c]) && lampReady[c] && $past(lampSync[c])
            |-> lampInput[c] && !lampSync[c])
         else $error("armed sync channel not switched to input");
   end
endmodule
bind chmon_top chmon_top_chk chk (.core_clk(core_clk), .rst(rst), .ce(ce),
   .recordStart(recordStart), .recordRun(recordRun),
   .transportStop(transportStop), .lampSafe(lampSafe),
   .lampReady(lampReady), .lampRecord(lampRecord), .lampSync(lampSync),
   .lampRepro(lampRepro), .lampInput(lampInput), .lampBias(lampBias),
   .lampErase(lampErase));
`default_nettype wire

// ---- verif/chmon_panel_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module chmon_panel_model #(
   parameter int HOLD = 40
) (
   input wire logic core_clk,
   input wire logic go,
   input wire logic [3:0] selReq,
   input wire logic [4:0] fnReq,
   output logic [3:0] panelSel,
   output logic [4:0] panelFn,
   output logic busy
);
   // Contacts chatter before settling; a released button reads low
   // through its pull-down, and stays released long enough to be seen
   initial begin
      panelSel = 4'h0;
      panelFn = 5'h0;
      busy = 1'h0;
      forever begin
         @(posedge core_clk);
         if (go) begin
            busy <= 1'h1;
            for (int i = 0; i < 6; i++) begin
               panelSel <= i[0] ? selReq : 4'h0;
               panelFn <= i[0] ? fnReq : 5'h0;
               @(posedge core_clk);
            end
            panelSel <= selReq;
            panelFn <= fnReq;
            repeat (HOLD) @(posedge core_clk);
            panelSel <= 4'h0;
            panelFn <= 5'h0;
            repeat (HOLD) @(posedge core_clk);
            busy <= 1'h0;
         end
      end
   end
endmodule
`default_nettype wire

// ---- verif/channel_monitor_mode_control_test.sv ----
`timescale 1ns/1ns
`default_nettype none
module channel_monitor_mode_control_test;
   import chmon_pkg::*;
   localparam int DB = 8;
   logic core_clk = 1'h0, rst = 1'h1, ce = 1'h1, go = 1'h0, busy;
   logic supply = 1'h0, takeup = 1'h0, recStart = 1'h0, recRun = 1'h1;
   logic rethread = 1'h0, awValid = 1'h0, wValid = 1'h0, bReady = 1'h0;
   logic arValid = 1'h0, rReady = 1'h0, awReady, wReady, bValid;
   logic arReady, rValid, stop, unthread, freeze;
   logic [1:0] bResp, rResp;
   logic [3:0] awAddr = 4'h0, arAddr = 4'h0, selReq = 4'h0, panelSel;
   logic [4:0] fnReq = 5'h0, panelFn;
   logic [31:0] wData = 32'h0, rData;
   logic [3:0] lSafe, lReady, lRec, lSync, lRepro, lInput, lBias, lErase;
   logic [3:0] rRepro, rSync, rIn;
   int errCount = 0, checks = 0;

   always #10 core_clk = ~core_clk;

   chmon_top #(.DEBOUNCE_LEN(DB)) dut (.core_clk(core_clk), .rst(rst),
      .ce(ce), .panelSel(panelSel), .panelFn(panelFn),
      .tapeOutSupply(supply), .tapeOutTakeup(takeup),
      .recordStart(recStart), .recordRun(recRun), .rethread(rethread),
      .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
      .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
      .s_axi_bvalid(bValid), .s_axi_bready(bReady),
      .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
      .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
      .s_axi_rvalid(rValid), .s_axi_rready(rReady), .lampSafe(lSafe),
      .lampReady(lReady), .lampRecord(lRec), .lampSync(lSync),
      .lampRepro(lRepro), .lampInput(lInput), .lampBias(lBias),
      .lampErase(lErase), .routeRecHead(rSync), .routeReproHead(rRepro),
      .routeInput(rIn), .transportStop(stop), .unthreadMode(unthread),
      .timerFreeze(freeze));

   chmon_panel_model #(.HOLD(5 * DB)) panel (.core_clk(core_clk),
      .go(go), .selReq(selReq), .fnReq(fnReq), .panelSel(panelSel),
      .panelFn(panelFn), .busy(busy));

   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------
   task automatic chk(input string what, input logic [31:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         errCount++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wt(input int n);
      repeat (n) @(posedge core_clk);
   endtask

   function automatic logic [7:0] lamps(input int c);
      return {lSafe[c], lReady[c], lRec[c], lSync[c], lRepro[c],
         lInput[c], lBias[c], lErase[c]};
   endfunction

   task automatic axw(input logic [3:0] a, input logic [31:0] d,
         input logic [1:0] exp);
      @(posedge core_clk);
      awAddr <= a;
      wData <= d;
      awValid <= 1'h1;
      wValid <= 1'h1;
      bReady <= 1'h1;
      do begin
         @(posedge core_clk);
         if (awReady) awValid <= 1'h0;
         if (wReady) wValid <= 1'h0;
      end while (bValid !== 1'h1);
      bReady <= 1'h0;
      chk("bresp", 32'(bResp), 32'(exp));
   endtask

   task automatic axr(input logic [3:0] a, output logic [31:0] d,
         output logic [1:0] r);
      @(posedge core_clk);
      arAddr <= a;
      arValid <= 1'h1;
      rReady <= 1'h1;
      do begin
         @(posedge core_clk);
         if (arReady) arValid <= 1'h0;
      end while (rValid !== 1'h1);
      rReady <= 1'h0;
      d = rData;
      r = rResp;
   endtask

   task automatic cmd(input logic [3:0] m, input int f);
      axw(REG_CMD, (32'(m) << CMD_CH_LSB) | (32'h1 << (CMD_FN_LSB + f)),
         RESP_OKAY);
      wt(2);
   endtask

   task automatic press(input logic [3:0] s, input logic [4:0] f);
      @(posedge core_clk);
      selReq <= s;
      fnReq <= f;
      go <= 1'h1;
      @(posedge core_clk);
      go <= 1'h0;
      do begin
         @(posedge core_clk);
      end while (busy !== 1'h0);
   endtask

   task automatic recPulse;
      @(posedge core_clk);
      recStart <= 1'h1;
      @(posedge core_clk);
      recStart <= 1'h0;
      wt(3);
   endtask

   // ------------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------------
   task automatic tReset;
      logic [31:0] d;
      logic [1:0] r;
      for (int c = 0; c < CH_COUNT; c++) chk("reset", lamps(c), 8'h88);
      axr(REG_LAMPS, d, r);
      chk("lamp word", d, 32'h000F000F);
      chk("runoff", {stop, unthread, freeze}, 3'h0);
   endtask

   task automatic tRecord;
      press(4'h4, 5'h0);
      chk("select alone", lamps(2), 8'h88);
      press(4'h2, 5'h1 << FN_SYNC);
      chk("sync chord", lamps(1), 8'h90);
      chk("sync route", rSync[1], 1'h1);
      press(4'h2, 5'h1 << FN_READY);
      chk("ready to input", lamps(1), 8'h44);
      recPulse();
      chk("recording", lamps(1), 8'h27);
      chk("safe blocked", lamps(0), 8'h88);
      recRun <= 1'h0;
      wt(3);
      chk("record ends", lamps(1), 8'h50);
      recRun <= 1'h1;
      recPulse();
      chk("sync rearm", lamps(1), 8'h27);
      cmd(4'h2, FN_INPUT);
      chk("input in record", lamps(1), 8'h27);
      cmd(4'h2, FN_SAFE);
      chk("forced safe", lamps(1), 8'h84);
      chk("other channel", lamps(0), 8'h88);
      recPulse();
      chk("safe no record", lamps(1), 8'h84);
   endtask

   task automatic tModes;
      logic [31:0] d;
      logic [1:0] r;
      for (int c = 0; c < CH_COUNT; c++) begin
         cmd(4'(1 << c), FN_REPRO);
         axr(REG_STATUS, d, r);
         chk("repro", {rRepro[c], d[ST_MON_LSB + 2 * c +: 2]}, 3'h5);
         cmd(4'(1 << c), FN_INPUT);
         axr(REG_STATUS, d, r);
         chk("input", {lInput[c], rIn[c], d[ST_MON_LSB + 2 * c +: 2]},
            4'hE);
      end
   endtask

   task automatic tBus;
      logic [31:0] d;
      logic [1:0] r;
      axw(REG_CTRL, 32'h0, RESP_OKAY);
      press(4'h1, 5'h1 << FN_SYNC);
      chk("panel masked", lamps(0), 8'h84);
      axw(REG_CTRL, 32'h1, RESP_OKAY);
      axw(REG_STATUS, 32'hFFFFFFFF, RESP_OKAY);
      axr(4'h1, d, r);
      chk("unmapped resp", 32'(r), 32'(RESP_SLVERR));
   endtask

   task automatic tRunoff;
      cmd(4'h8, FN_READY);
      recPulse();
      chk("ch3 record", lRec[3], 1'h1);
      ce <= 1'h0;
      recRun <= 1'h0;
      wt(3);
      chk("frozen by enable", lRec[3], 1'h1);
      ce <= 1'h1;
      recRun <= 1'h1;
      for (int p = 0; p < 2; p++) begin
         {supply, takeup} <= 2'(p + 1);
         wt(4 * DB);
         chk("runoff", {stop, unthread, freeze, lRec[3]}, 4'hE);
         {supply, takeup} <= 2'h0;
         wt(4 * DB);
         rethread <= 1'h1;
         wt(2);
         rethread <= 1'h0;
         wt(2);
         chk("rethread", {stop, lReady[3]}, 2'h1);
      end
   endtask

   task automatic print_verdict;
      if (errCount == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   initial begin
      wt(20);
      rst <= 1'h0;
      wt(2);
      tReset();
      tRecord();
      tModes();
      tBus();
      tRunoff();
      print_verdict();
   end

   // Whole run is near 630 cycles; a hang is cut well after that
   initial begin
      wt(8000);
      errCount++;
      print_verdict();
   end
endmodule
`default_nettype wire
